// ---- pkg/rcd_pkg.sv ----
// Package with register offsets, field positions, reset values and timing constants for the respiration and drive control.
`default_nettype none
package rcd_pkg;
	// Register indices on the plain register port.
	localparam logic [3:0] RCD_ADDR_CONFIG_REGISTER_THREE = 4'h3;
	localparam logic [3:0] RCD_ADDR_ELECTRODE_OFF_CONFIG_REGISTER    = 4'h4;
	localparam logic [3:0] RCD_ADDR_PACE    = 4'h5;
	localparam logic [3:0] RCD_ADDR_RESPIRATION_REGISTER    = 4'h6;
	localparam logic [3:0] RCD_ADDR_CONFIG_REGISTER_FOUR = 4'h7;
	localparam logic [3:0] RCD_ADDR_GPIO    = 4'h8;
	localparam logic [3:0] RCD_ADDR_STATUS  = 4'h9;

	// Reset values.
	localparam logic [7:0] RCD_RST_CONFIG_REGISTER_THREE = 8'h00;
	localparam logic [7:0] RCD_RST_ELECTRODE_OFF_CONFIG_REGISTER    = 8'h00;
	localparam logic [7:0] RCD_RST_PACE    = 8'h00;
	localparam logic [7:0] RCD_RST_RESPIRATION_REGISTER    = 8'h00;
	localparam logic [7:0] RCD_RST_CONFIG_REGISTER_FOUR = 8'h00;
	localparam logic [7:0] RCD_RST_GPIO    = 8'h0F;

	// Field positions.
	localparam int RCD_C3_BIAS_PD      = 2;
	localparam int RCD_C3_REF_INT      = 3;
	localparam int RCD_C4_RATE_LSB     = 5;
	localparam int RCD_C4_CT_TO_BIAS   = 2;
	localparam int RCD_ELECTRODE_OFF_CONFIG_REGISTER_TH_LSB     = 5;
	localparam int RCD_PACE_PD         = 0;
	localparam int RCD_PACE_EVEN_LSB   = 1;
	localparam int RCD_PACE_ODD_LSB    = 3;
	localparam int RCD_RESPIRATION_PHASE_SELECT_LSB     = 2;
	localparam int RCD_RESPIRATION_REGISTER_MODE_LSB   = 0;
	localparam logic [1:0] RCD_MODE_EXT = 2'h1;

	// Respiration clock half-period base and settling count.
	localparam int RCD_RESPIRATION_REGISTER_BASE_CYCLES = 16;
	localparam logic [1:0] RCD_SETTLE_PERIODS = 2'h3;
endpackage
`default_nettype wire

// ---- rtl/rcd_top.sv ----
// Respiration clock generation, bias drive, electrode-off and pacer routing control.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Mode 00 no clocks, 01 drives clocks.
// - External mode forces respiration pins to outputs.
// - In-phase, quadrature, and their XOR on pins.
// - Clock rate from config four rate field.
// - Phase offset from respiration phase field.
// - Route one odd, one even channel.
// - Pacer signals muxed with test signals.
// - Pacer amplifier powerdown bit turns amplifiers off.
// - Pulse-detect pin data reported to register port.
// - Samples invalid until three periods after step.
// - Bias reference internal or external select.
// - Powerdown bit disables bias drive amplifier.
// - Central terminal buffered onto bias drive path.
// - Bias threshold uses electrode-off bits seven-five.
// - Amp on disables bias electrode-off current source.
// The block has one clock; the only asynchronous inputs are the pin levels,
// which pass a two-stage synchroniser before anything reads them.
// Limitation: while mode 01 owns the upper three pins, only pin zero stays
// free, so that is where an external pulse detector must report its result.
// The general-purpose register keeps its value through mode 01, so leaving
// the mode restores exactly the pin setup that software had before.
module rcd_top
	import rcd_pkg::*;
(
	// Clock, reset and the clock enable that freezes all state.
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       clk_en_i,
	// Register port; read data answers one cycle after the read strobe.
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Shared pins; a low output enable means the pin is driven.
	input  wire logic [3:0] gpio_in_i,
	output logic      [3:0] gpio_out_o,
	output logic      [3:0] gpio_oe_n_o,
	// Output data period ticks and input step events from the filter.
	input  wire logic       sample_tick_i,
	input  wire logic       step_event_i,
	output logic            sample_valid_o,
	// Pacer routing and bias drive controls.
	input  wire logic       test_sel_i,
	output logic      [2:0] pace_odd_sel_o,
	output logic      [2:0] pace_even_sel_o,
	output logic            pace_route_pace_o,
	output logic            pace_amp_en_o,
	output logic            bias_amp_en_o,
	output logic            bias_ref_internal_o,
	output logic            ct_to_bias_o,
	output logic      [2:0] bias_electrode_off_config_register_threshold_o,
	output logic            bias_electrode_off_config_register_isrc_en_o
);
	logic [7:0] cfg3;
	logic [7:0] electrode_off_config_register;
	logic [7:0] pace;
	logic [7:0] respiration_register;
	logic [7:0] cfg4;
	logic [7:0] gpio;
	logic [7:0] next_cfg3;
	logic [7:0] next_electrode_off_config_register;
	logic [7:0] next_pace;
	logic [7:0] next_respiration_register;
	logic [7:0] next_cfg4;
	logic [7:0] next_gpio;
	logic [7:0] next_rdata;
	logic [3:0] gpio_s1;
	logic [3:0] gpio_s2;
	logic [9:0] div_cnt;
	logic [9:0] next_div_cnt;
	logic [2:0] ph_seq;
	logic [2:0] next_ph_seq;
	logic [1:0] settle_cnt;
	logic [1:0] next_settle_cnt;
	logic [3:0] next_gpio_out;
	logic [3:0] next_gpio_oe_n;
	logic       respiration_register_on;
	logic       clk_i_ph;
	logic       clk_q_ph;
	logic       settled;
	logic [9:0] step_len;
	// Register fields pulled out by name so the decode below reads like the register map.
	logic [1:0] mode_code;
	logic [2:0] rate_code;
	logic [2:0] phase_code;
	logic       bias_pd_bit;
	logic       ref_int_bit;
	logic       ct_bit;
	logic [2:0] electrode_off_config_register_th_code;
	logic       pace_pd_bit;
	logic [1:0] pace_even_code;
	logic [1:0] pace_odd_code;
	// Next values of the registered control outputs.
	logic       next_sample_valid;
	logic [2:0] next_pace_odd_sel;
	logic [2:0] next_pace_even_sel;
	logic       next_pace_route;
	logic       next_pace_amp_en;
	logic       next_bias_amp_en;
	logic       next_bias_ref_int;
	logic       next_ct_to_bias;
	logic [2:0] next_bias_electrode_off_config_register_th;
	logic       next_bias_electrode_off_config_register_isrc;

	// Two-stage synchroniser for pin inputs before any logic reads them.
	// The first stage may go metastable, so only the second stage is ever read.
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			gpio_s1 <= 4'h0;
			gpio_s2 <= 4'h0;
		end
		else if (clk_en_i)
		begin
			gpio_s1 <= gpio_in_i;
			gpio_s2 <= gpio_s1;
		end
	end

	// Register writes and read data; unmapped addresses read as zero.
	// Reads have no side effects, so a read may follow a write with no gap.
	always_comb
	begin
		next_cfg3  = cfg3;
		next_electrode_off_config_register  = electrode_off_config_register;
		next_pace  = pace;
		next_respiration_register  = respiration_register;
		next_cfg4  = cfg4;
		next_gpio  = gpio;
		next_rdata = 8'h00;
		if (wr_i)
		begin
			case (addr_i)
				RCD_ADDR_CONFIG_REGISTER_THREE: next_cfg3 = wdata_i;
				RCD_ADDR_ELECTRODE_OFF_CONFIG_REGISTER:    next_electrode_off_config_register = wdata_i;
				RCD_ADDR_PACE:    next_pace = wdata_i;
				RCD_ADDR_RESPIRATION_REGISTER:    next_respiration_register = wdata_i;
				RCD_ADDR_CONFIG_REGISTER_FOUR: next_cfg4 = wdata_i;
				RCD_ADDR_GPIO:    next_gpio = wdata_i;
				default:          next_gpio = gpio;
			endcase
		end
		if (rd_i)
		begin
			case (addr_i)
				RCD_ADDR_CONFIG_REGISTER_THREE: next_rdata = cfg3;
				RCD_ADDR_ELECTRODE_OFF_CONFIG_REGISTER:    next_rdata = electrode_off_config_register;
				RCD_ADDR_PACE:    next_rdata = pace;
				RCD_ADDR_RESPIRATION_REGISTER:    next_rdata = respiration_register;
				RCD_ADDR_CONFIG_REGISTER_FOUR: next_rdata = cfg4;
				// Pin levels sit in the upper nibble so the pulse-detect result is seen by software.
				RCD_ADDR_GPIO:    next_rdata = {gpio_s2, gpio[3:0]};
				RCD_ADDR_STATUS:  next_rdata = {5'h00, settled, respiration_register_on, clk_i_ph};
				default:          next_rdata = 8'h00;
			endcase
		end
	end

	// Register storage.
	// Clock enable low freezes every register, the read data included.
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			cfg3    <= RCD_RST_CONFIG_REGISTER_THREE;
			electrode_off_config_register    <= RCD_RST_ELECTRODE_OFF_CONFIG_REGISTER;
			pace    <= RCD_RST_PACE;
			respiration_register    <= RCD_RST_RESPIRATION_REGISTER;
			cfg4    <= RCD_RST_CONFIG_REGISTER_FOUR;
			gpio    <= RCD_RST_GPIO;
			rdata_o <= 8'h00;
		end
		else if (clk_en_i)
		begin
			cfg3    <= next_cfg3;
			electrode_off_config_register    <= next_electrode_off_config_register;
			pace    <= next_pace;
			respiration_register    <= next_respiration_register;
			cfg4    <= next_cfg4;
			gpio    <= next_gpio;
			rdata_o <= next_rdata;
		end
	end

	// Field extraction from the stored registers.
	assign mode_code      = respiration_register[RCD_RESPIRATION_REGISTER_MODE_LSB +: 2];
	assign phase_code     = respiration_register[RCD_RESPIRATION_PHASE_SELECT_LSB +: 3];
	assign rate_code      = cfg4[RCD_C4_RATE_LSB +: 3];
	assign ct_bit         = cfg4[RCD_C4_CT_TO_BIAS];
	assign bias_pd_bit    = cfg3[RCD_C3_BIAS_PD];
	assign ref_int_bit    = cfg3[RCD_C3_REF_INT];
	assign electrode_off_config_register_th_code   = electrode_off_config_register[RCD_ELECTRODE_OFF_CONFIG_REGISTER_TH_LSB +: 3];
	assign pace_pd_bit    = pace[RCD_PACE_PD];
	assign pace_even_code = pace[RCD_PACE_EVEN_LSB +: 2];
	assign pace_odd_code  = pace[RCD_PACE_ODD_LSB +: 2];

	// Only mode 01 produces clocks; every other code behaves like mode 00.
	assign respiration_register_on  = mode_code == RCD_MODE_EXT;
	// One sequencer step is a quarter of the half period; higher rate codes give shorter steps.
	// Counting quarter steps keeps the divider at ten bits even at the slowest rate.
	assign step_len = 10'(RCD_RESPIRATION_REGISTER_BASE_CYCLES / 4) << (3'h7 - rate_code);
	// Eight-step sequence: in-phase high in steps 0 to 3, quadrature lags by the phase field in steps.
	assign clk_i_ph = ph_seq < 3'h4;
	assign clk_q_ph = 3'(ph_seq - phase_code) < 3'h4;
	// Status bit: no step is still settling.
	assign settled  = settle_cnt == 2'h0;

	// Divider and phase sequencer; held at zero outside external mode so a restart begins cleanly.
	// The compare is greater-or-equal so a change to a shorter step never lets the counter run past it.
	always_comb
	begin
		next_div_cnt = div_cnt;
		next_ph_seq  = ph_seq;
		if (!respiration_register_on)
		begin
			next_div_cnt = 10'h000;
			next_ph_seq  = 3'h0;
		end
		else if (div_cnt >= 10'(step_len - 10'h001))
		begin
			next_div_cnt = 10'h000;
			next_ph_seq  = 3'(ph_seq + 3'h1);
		end
		else
		begin
			next_div_cnt = 10'(div_cnt + 10'h001);
		end
	end

	// Pin drive: all three clocks come from one register stage on the same edge.
	always_comb
	begin
		// General-purpose setup: a set low-nibble bit makes the pin an input, the upper nibble is driven out.
		next_gpio_out  = gpio[7:4];
		next_gpio_oe_n = gpio[3:0];
		if (respiration_register_on)
		begin
			next_gpio_out[1]  = clk_i_ph ^ clk_q_ph;
			next_gpio_out[2]  = clk_i_ph;
			next_gpio_out[3]  = clk_q_ph;
			next_gpio_oe_n[3:1] = 3'h0;
		end
		// Leaving mode 01 lets the general-purpose setup above take the pins back.
	end

	// Settling counter: samples valid three output periods after a step.
	// A new step restarts the count, even in the middle of an earlier one.
	always_comb
	begin
		next_settle_cnt = settle_cnt;
		if (step_event_i)
		begin
			next_settle_cnt = RCD_SETTLE_PERIODS;
		end
		else if (sample_tick_i && settle_cnt != 2'h0)
		begin
			next_settle_cnt = 2'(settle_cnt - 2'h1);
		end
	end

	// Control outputs: each but the sample flag and the pacer route is a plain decode of one register field, registered once.
	always_comb
	begin
		// A sample counts as valid on every tick that leaves the settling count at zero, from the one that finishes it on.
		next_sample_valid   = sample_tick_i && next_settle_cnt == 2'h0;
		// Odd channels 1,3,5,7 and even channels 2,4,6,8 as zero-based channel indices.
		next_pace_odd_sel   = {pace_odd_code, 1'b0};
		next_pace_even_sel  = {pace_even_code, 1'b1};
		// With the amplifiers off the test signals own the shared pins, whatever the test select says.
		next_pace_route     = !pace_pd_bit && !test_sel_i;
		next_pace_amp_en    = !pace_pd_bit;
		next_bias_amp_en    = !bias_pd_bit;
		next_bias_ref_int   = ref_int_bit;
		next_ct_to_bias     = ct_bit;
		next_bias_electrode_off_config_register_th   = electrode_off_config_register_th_code;
		// The current source only matters with the amplifier off; with it on it would load the loop.
		next_bias_electrode_off_config_register_isrc = bias_pd_bit;
	end

	// Sequencer and pin registers: all three clocks leave one register stage on the same edge.
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			div_cnt        <= 10'h000;
			ph_seq         <= 3'h0;
			settle_cnt     <= 2'h0;
			gpio_out_o     <= 4'h0;
			gpio_oe_n_o    <= 4'hF;
			sample_valid_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			div_cnt        <= next_div_cnt;
			ph_seq         <= next_ph_seq;
			settle_cnt     <= next_settle_cnt;
			gpio_out_o     <= next_gpio_out;
			gpio_oe_n_o    <= next_gpio_oe_n;
			sample_valid_o <= next_sample_valid;
		end
	end

	// Control output registers.
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			pace_odd_sel_o        <= 3'h0;
			pace_even_sel_o       <= 3'h0;
			pace_route_pace_o     <= 1'b0;
			pace_amp_en_o         <= 1'b0;
			bias_amp_en_o         <= 1'b0;
			bias_ref_internal_o   <= 1'b0;
			ct_to_bias_o          <= 1'b0;
			bias_electrode_off_config_register_threshold_o <= 3'h0;
			bias_electrode_off_config_register_isrc_en_o   <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pace_odd_sel_o        <= next_pace_odd_sel;
			pace_even_sel_o       <= next_pace_even_sel;
			pace_route_pace_o     <= next_pace_route;
			pace_amp_en_o         <= next_pace_amp_en;
			bias_amp_en_o         <= next_bias_amp_en;
			bias_ref_internal_o   <= next_bias_ref_int;
			ct_to_bias_o          <= next_ct_to_bias;
			bias_electrode_off_config_register_threshold_o <= next_bias_electrode_off_config_register_th;
			bias_electrode_off_config_register_isrc_en_o   <= next_bias_electrode_off_config_register_isrc;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/rcd_monitor.sv ----
// Checker for the respiration and drive control ports.
`timescale 1ns/10ps
`default_nettype none
module rcd_monitor
	import rcd_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       reset_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic [3:0] gpio_out_o,
	input wire logic [3:0] gpio_oe_n_o,
	input wire logic       test_sel_i,
	input wire logic [2:0] pace_odd_sel_o,
	input wire logic [2:0] pace_even_sel_o,
	input wire logic       pace_route_pace_o,
	input wire logic       pace_amp_en_o,
	input wire logic       bias_amp_en_o,
	input wire logic       bias_ref_internal_o,
	input wire logic       ct_to_bias_o,
	input wire logic [2:0] bias_electrode_off_config_register_threshold_o,
	input wire logic       bias_electrode_off_config_register_isrc_en_o
);
	// One clock domain; reset blanks every check.
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic respiration_register_seen;
	// Mode tracked from the writes alone, so pin checks run only while clocks are expected.
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			respiration_register_seen <= 1'b0;
		else if (wr_i && addr_i == RCD_ADDR_RESPIRATION_REGISTER)
			respiration_register_seen <= wdata_i[1:0] == RCD_MODE_EXT;
	end
	a_bias_cfg: assert property (wr_i && addr_i == RCD_ADDR_CONFIG_REGISTER_THREE |-> ##2
		bias_amp_en_o == !$past(wdata_i[2], 2) && bias_ref_internal_o == $past(wdata_i[3], 2))
		else $error("bias config not followed");
	a_ct_follow: assert property (wr_i && addr_i == RCD_ADDR_CONFIG_REGISTER_FOUR |-> ##2
		ct_to_bias_o == $past(wdata_i[2], 2)) else $error("central terminal bit not followed");
	a_electrode_off_config_register_thresh: assert property (wr_i && addr_i == RCD_ADDR_ELECTRODE_OFF_CONFIG_REGISTER |-> ##2
		bias_electrode_off_config_register_threshold_o == $past(wdata_i[7:5], 2)) else $error("threshold not followed");
	a_pace_cfg: assert property (wr_i && addr_i == RCD_ADDR_PACE |-> ##2
		pace_odd_sel_o == {$past(wdata_i[4:3], 2), 1'b0} && pace_even_sel_o == {$past(wdata_i[2:1], 2), 1'b1}
		&& pace_amp_en_o == !$past(wdata_i[0], 2)) else $error("pacer config not followed");
	a_test_mux: assert property (test_sel_i [*3] |-> !pace_route_pace_o)
		else $error("pacer routed while test selected");
	a_isrc_off: assert property (bias_amp_en_o && $past(bias_amp_en_o) |-> !bias_electrode_off_config_register_isrc_en_o)
		else $error("current source on with amplifier on");
	a_respiration_register_drive: assert property (wr_i && addr_i == RCD_ADDR_RESPIRATION_REGISTER && wdata_i[1:0] == 2'h1 |-> ##2
		gpio_oe_n_o[3:1] == 3'h0) else $error("respiration pins not driven");
	a_respiration_register_xor: assert property (respiration_register_seen && $past(respiration_register_seen) |->
		gpio_oe_n_o[3:1] == 3'h0 && gpio_out_o[1] == (gpio_out_o[2] ^ gpio_out_o[3])) else $error("xor pin wrong");
endmodule
`default_nettype wire

// ---- testbench/rcd_partner.sv ----
// Model of the external pace detector and the wiring of the shared pins.
`timescale 1ns/10ps
`default_nettype none
module rcd_partner (
	input  wire logic       ref_clk_i,
	input  wire logic       pace_det_i,
	input  wire logic [3:0] gpio_out_i,
	input  wire logic [3:0] gpio_oe_n_i,
	output logic      [3:0] gpio_in_o
);
	logic [3:0] float_q = 4'h5;
	// Undriven pins wander every cycle so a stale value never reads as a match.
	always_ff @(posedge ref_clk_i) float_q <= ~float_q;
	// The pace detector drives the first pin while the device leaves it as an input.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			gpio_in_o[i] = gpio_oe_n_i[i] ? ((i == 0) ? pace_det_i : float_q[i]) : gpio_out_i[i];
	end
endmodule
`default_nettype wire

// ---- testbench/rcd_top_tb_top.sv ----
// Testbench for the respiration and drive control.
`timescale 1ns/10ps
`default_nettype none
module rcd_top_tb_top;
	import rcd_pkg::*;
	logic       ref_clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, test_sel_i = 1'b0;
	logic       sample_tick_i = 1'b0, step_event_i = 1'b0, pace_det = 1'b0, sample_valid_o, pace_route_pace_o;
	logic [3:0] addr_i = 4'h0, gpio_in_i, gpio_out_o, gpio_oe_n_o;
	logic [7:0] wdata_i = 8'h00, rdata_o, d;
	logic [2:0] pace_odd_sel_o, pace_even_sel_o, bias_electrode_off_config_register_threshold_o;
	logic       pace_amp_en_o, bias_amp_en_o, bias_ref_internal_o, ct_to_bias_o, bias_electrode_off_config_register_isrc_en_o;
	int         fails = 0, n_checks = 0, cnt;
	rcd_top uut (.ref_clk_i, .reset_n_i, .clk_en_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .gpio_in_i,
		.gpio_out_o, .gpio_oe_n_o, .sample_tick_i, .step_event_i, .sample_valid_o, .test_sel_i, .pace_odd_sel_o,
		.pace_even_sel_o, .pace_route_pace_o, .pace_amp_en_o, .bias_amp_en_o, .bias_ref_internal_o,
		.ct_to_bias_o, .bias_electrode_off_config_register_threshold_o, .bias_electrode_off_config_register_isrc_en_o);
	rcd_partner u_far (.ref_clk_i, .pace_det_i(pace_det), .gpio_out_i(gpio_out_o), .gpio_oe_n_i(gpio_oe_n_o),
		.gpio_in_o(gpio_in_i));
	// Free-running 50 MHz clock.
	initial forever #10 ref_clk_i = ~ref_clk_i;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		{wr_i, addr_i, wdata_i} <= {1'b1, a, v};
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk_i);
		{rd_i, addr_i} <= {1'b1, a};
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// Counts cycles until a pin reaches a level; the bound stops a dead clock hanging the run.
	task automatic till(input int b, input logic lv);
		cnt = 0;
		while (gpio_out_o[b] !== lv && cnt < 5000)
		begin
			cyc(1);
			cnt++;
		end
	endtask
	task automatic tally_and_finish();
		$display("fails=%0d n_checks=%0d", fails, n_checks);
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well beyond the slowest respiration rate sweep.
	initial
	begin
		#1_500_000;
		fails++;
		tally_and_finish();
	end
	// Main sequence.
	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		for (int a = 3; a <= 7; a++)
		begin
			rd(a[3:0]);
			chk(d, 8'h00);
		end
		chk(gpio_oe_n_o, 4'hF);
		wr(4'hA, 8'hFF);
		rd(4'hA);
		chk(d, 8'h00);
		wr(RCD_ADDR_CONFIG_REGISTER_THREE, 8'h08);
		rd(RCD_ADDR_CONFIG_REGISTER_THREE);
		chk(d, 8'h08);
		wr(RCD_ADDR_ELECTRODE_OFF_CONFIG_REGISTER, 8'hA0);
		wr(RCD_ADDR_PACE, 8'h14);
		wr(RCD_ADDR_CONFIG_REGISTER_FOUR, 8'hE4);
		cyc(3);
		chk({bias_amp_en_o, bias_ref_internal_o, ct_to_bias_o, bias_electrode_off_config_register_threshold_o, pace_odd_sel_o, pace_even_sel_o,
			pace_amp_en_o, pace_route_pace_o, bias_electrode_off_config_register_isrc_en_o}, {3'h7, 3'h5, 3'h4, 3'h5, 3'h6});
		@(posedge ref_clk_i) test_sel_i <= 1'b1;
		cyc(3);
		chk(pace_route_pace_o, 1'b0);
		for (int lv = 0; lv < 2; lv++)
		begin
			@(posedge ref_clk_i) pace_det <= lv[0];
			cyc(4);
			rd(RCD_ADDR_GPIO);
			chk(d[4], lv[0]);
		end
		// Settling after an input step, ticks standing in for output data periods at 8kSPS or more.
		@(posedge ref_clk_i) step_event_i <= 1'b1;
		@(posedge ref_clk_i) step_event_i <= 1'b0;
		for (int i = 1; i <= 3; i++)
		begin
			@(posedge ref_clk_i) sample_tick_i <= 1'b1;
			@(posedge ref_clk_i) sample_tick_i <= 1'b0;
			#1 chk(sample_valid_o, i == 3);
		end
		wr(RCD_ADDR_RESPIRATION_REGISTER, 8'h01);
		cyc(2);
		chk(gpio_oe_n_o[3:1], 3'h0);
		for (int r = 0; r < 8; r++)
		begin
			wr(RCD_ADDR_CONFIG_REGISTER_FOUR, {r[2:0], 5'h04});
			till(2, 1'b0);
			till(2, 1'b1);
			till(2, 1'b0);
			chk(cnt, RCD_RESPIRATION_REGISTER_BASE_CYCLES << (7 - r));
		end
		for (int p = 0; p < 4; p++)
		begin
			wr(RCD_ADDR_RESPIRATION_REGISTER, {3'h0, p[2:0], 2'h1});
			till(2, 1'b0);
			till(2, 1'b1);
			till(3, 1'b1);
			chk(cnt, p * (RCD_RESPIRATION_REGISTER_BASE_CYCLES / 4));
		end
		wr(RCD_ADDR_RESPIRATION_REGISTER, 8'h00);
		wr(RCD_ADDR_PACE, 8'h15);
		wr(RCD_ADDR_CONFIG_REGISTER_THREE, 8'h04);
		cyc(3);
		chk({gpio_oe_n_o, pace_amp_en_o, bias_amp_en_o, bias_ref_internal_o}, 7'h78);
		tally_and_finish();
	end
endmodule
bind rcd_top rcd_monitor u_mon (.ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .gpio_out_o, .gpio_oe_n_o,
	.test_sel_i, .pace_odd_sel_o, .pace_even_sel_o, .pace_route_pace_o, .pace_amp_en_o, .bias_amp_en_o,
	.bias_ref_internal_o, .ct_to_bias_o, .bias_electrode_off_config_register_threshold_o, .bias_electrode_off_config_register_isrc_en_o);
`default_nettype wire
